// ===== verilog/sar_readout_pkg.sv
// Purpose: Shared constants and types for the serial SAR readout block
// Assumes: Falling edges of shift_clock are counted from chip select low
// Notes: Edge numbers are 1-based counts of shift_clock falls in a frame
`default_nettype none
package sar_readout_pkg;
  localparam int RESULT_W = 14;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 6;
  // Falling-edge numbers within a frame
  localparam logic [CNT_W-1:0] FALL_HOLD = 6'h05;
  localparam logic [CNT_W-1:0] FALL_MSB = 6'h06;
  localparam logic [CNT_W-1:0] FALL_LSB = 6'h13;
  localparam logic [CNT_W-1:0] FALL_DUMMY_END = 6'h15;
  localparam logic [CNT_W-1:0] FALL_REV_FIRST = 6'h16;
  localparam logic [CNT_W-1:0] FALL_REV_LAST = 6'h23;
  localparam logic [CNT_W-1:0] FALL_MAX = 6'h3f;
  localparam logic [RESULT_W-1:0] TRIAL_MSB = 14'h2000;
  localparam logic [RESULT_W-1:0] CODE_ZERO = 14'h0000;
  // Host-side timing, kept for reference by the bench
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCK_MIN_PHASE_NS = 200;
  localparam int SCK_MIN_PHASE_CYC =
    (SCK_MIN_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_TRAIL = 3'b011,
    ST_REPEAT = 3'b100
  } frame_state_t;

  typedef struct packed {
    logic data;
    logic oe;
  } serial_out_t;

  typedef struct packed {
    logic [RESULT_W-1:0] code;
  } result_word_t;
endpackage
`default_nettype wire

// ===== verilog/result_fifo.sv
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous push and pop
// Notes: Full and empty are exact; a push while full is refused by in_ready
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          mem_q[i] <= '0;
        else if (push && (wr_q[AW-1:0] == AW'(i)))
          mem_q[i] <= in_data;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verilog/sar_adc_serial_readout.sv
// Purpose: Conversion sequencing and serial readout of a 14-bit bipolar SAR converter
// Assumes: shift_clock and cs_n are synchronous to clk and slow against it
// Notes: Analog array is external: sample_en, dac_code out, comparator decision in
`default_nettype none
// How it works
// R1: Result leaves on serial data output MSB first, one bit per shift clock.
// R2: Bits shifted in a frame belong to that frame's own conversion.
// R3: Further clocks after the dummy bits repeat the result LSB first.
// R4: Host keeps shift clock between 24kHz and 1.2MHz, 24 periods per frame.
// R5: Host keeps each shift clock phase at least 200ns.
// R6: Input is sampled onto the array, then disconnected during conversion.
// R7: Sampling lasts until the fifth falling edge, then the value is held.
// R8: At the low-rate point chip select idles 216 of 240 cycles.
// R9: Chip select falling starts sampling and the frame.
// R10: After fifth fall output one low bit, result MSB first, two zeros.
// R11: Chip select high tri-states output; clocks then ignored until next fall.
// R12: Result is two's complement, LSB of twice reference over 16384.
// R13: With chip select high the device is powered down, no activity.
module sar_adc_serial_readout (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic shift_clock,
  output sar_readout_pkg::serial_out_t data_out,
  output logic sample_en,
  output logic [sar_readout_pkg::RESULT_W-1:0] dac_code,
  input wire logic comp_above,
  output logic power_down,
  output logic capture_ready,
  output logic result_valid,
  input wire logic result_ready,
  output sar_readout_pkg::result_word_t result_data
);
  sar_readout_pkg::frame_state_t state_q;
  sar_readout_pkg::frame_state_t state_d;
  logic sck_q;
  logic cs_n_q;
  logic sck_fall;
  logic cs_fall;
  logic [sar_readout_pkg::CNT_W-1:0] fall_cnt_q;
  logic [sar_readout_pkg::CNT_W-1:0] fall_next;
  logic [sar_readout_pkg::RESULT_W-1:0] trial_q;
  logic [sar_readout_pkg::RESULT_W-1:0] code_q;
  logic [sar_readout_pkg::RESULT_W-1:0] bit_idx;
  logic [sar_readout_pkg::RESULT_W-1:0] rev_idx;
  logic out_bit_q;
  logic out_oe_q;
  logic push_q;
  logic [sar_readout_pkg::RESULT_W-1:0] decided;

  // Falls are seen one clk after the pin moves; host phases are far longer
  assign sck_fall = sck_q && !shift_clock;
  assign cs_fall = cs_n_q && !cs_n;
  // Saturating count, so a host that clocks on cannot wrap into a new frame
  assign fall_next = (fall_cnt_q == sar_readout_pkg::FALL_MAX) ? fall_cnt_q
                   : fall_cnt_q + 1'b1;
  // One-hot weight of the bit decided on this fall
  assign bit_idx = sar_readout_pkg::TRIAL_MSB >> (fall_next - sar_readout_pkg::FALL_MSB);
  // Result bit position read back during the LSB-first repeat
  assign rev_idx = sar_readout_pkg::RESULT_W'(fall_next - sar_readout_pkg::FALL_REV_FIRST);
  // Comparator keeps or drops the trial bit; offset binary inside the array
  assign decided = comp_above ? trial_q : (trial_q & ~bit_idx);

  // Pins are synchronous to clk; the copies reset to their idle levels
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end
    else
    begin
      sck_q <= shift_clock;
      cs_n_q <= cs_n;
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sar_readout_pkg::ST_POWER_DOWN:
        // R9 frame start
        if (cs_fall)
          state_d = sar_readout_pkg::ST_SAMPLE;
      sar_readout_pkg::ST_SAMPLE:
        // R7 hold on fifth fall
        if (sck_fall && fall_next == sar_readout_pkg::FALL_HOLD)
          state_d = sar_readout_pkg::ST_CONVERT;
      sar_readout_pkg::ST_CONVERT:
        if (sck_fall && fall_next == sar_readout_pkg::FALL_LSB)
          state_d = sar_readout_pkg::ST_TRAIL;
      sar_readout_pkg::ST_TRAIL:
        if (sck_fall && fall_next == sar_readout_pkg::FALL_DUMMY_END)
          state_d = sar_readout_pkg::ST_REPEAT;
      sar_readout_pkg::ST_REPEAT:
        state_d = sar_readout_pkg::ST_REPEAT;
      default:
        state_d = sar_readout_pkg::ST_POWER_DOWN;
    endcase
    // R11 chip select high ends the frame
    if (cs_n)
      state_d = sar_readout_pkg::ST_POWER_DOWN;
  end

  // Chip select high wins over every state, so a cut frame ends cleanly
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= sar_readout_pkg::ST_POWER_DOWN;
    else
      state_q <= state_d;
  end

  // Falls are counted from one and cleared whenever the frame is over
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fall_cnt_q <= '0;
    else if (state_d == sar_readout_pkg::ST_POWER_DOWN || cs_fall)
      fall_cnt_q <= '0;
    else if (sck_fall)
      fall_cnt_q <= fall_next;
  end

  // Successive approximation, one decision per shift clock fall
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trial_q <= sar_readout_pkg::CODE_ZERO;
      code_q <= sar_readout_pkg::CODE_ZERO;
    end
    else if (cs_fall)
    begin
      trial_q <= sar_readout_pkg::CODE_ZERO;
      code_q <= sar_readout_pkg::CODE_ZERO;
    end
    else if (sck_fall && state_q == sar_readout_pkg::ST_SAMPLE
             && fall_next == sar_readout_pkg::FALL_HOLD)
      // R7 first trial at mid-scale once the input is held
      trial_q <= sar_readout_pkg::TRIAL_MSB;
    else if (sck_fall && state_q == sar_readout_pkg::ST_CONVERT
             && fall_next >= sar_readout_pkg::FALL_MSB)
    begin
      // R2 result built inside the current frame
      trial_q <= decided | (bit_idx >> 1);
      code_q <= decided;
    end
  end

  // Serial output stage; each bit changes on a shift clock fall
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_bit_q <= 1'b0;
      out_oe_q <= 1'b0;
    end
    else if (state_d == sar_readout_pkg::ST_POWER_DOWN)
    begin
      // R11 tri-state output
      out_bit_q <= 1'b0;
      out_oe_q <= 1'b0;
    end
    else if (sck_fall)
    begin
      if (fall_next == sar_readout_pkg::FALL_HOLD)
      begin
        // R10 enable with one low bit
        out_oe_q <= 1'b1;
        out_bit_q <= 1'b0;
      end
      else if (fall_next >= sar_readout_pkg::FALL_MSB && fall_next <= sar_readout_pkg::FALL_LSB)
        // R1 MSB first; R12 sign bit inverted from offset binary
        out_bit_q <= (fall_next == sar_readout_pkg::FALL_MSB) ? !comp_above : comp_above;
      else if (fall_next >= sar_readout_pkg::FALL_REV_FIRST
               && fall_next <= sar_readout_pkg::FALL_REV_LAST)
        // R3 LSB-first repeat
        out_bit_q <= (code_q[rev_idx[3:0]]) ^ (rev_idx == 14'(sar_readout_pkg::RESULT_W - 1));
      else
        // R10 dummy zeros and trailing zeros
        out_bit_q <= 1'b0;
    end
  end

  // Completed result is queued once per frame at the second dummy bit
  // A full queue drops the word; the drain sees it as capture_ready low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      push_q <= 1'b0;
    else
      push_q <= sck_fall && state_q == sar_readout_pkg::ST_TRAIL
                && fall_next == sar_readout_pkg::FALL_DUMMY_END && !cs_n;
  end

  // Both pin controls come straight from flops, so they never glitch
  assign data_out.data = out_bit_q;
  assign data_out.oe = out_oe_q;
  // R6 input connected only while sampling
  assign sample_en = (state_q == sar_readout_pkg::ST_SAMPLE);
  assign dac_code = trial_q;
  // R13 power-down whenever chip select is high
  assign power_down = (state_q == sar_readout_pkg::ST_POWER_DOWN);

  // Two's complement code is the offset-binary code with the sign bit flipped
  result_fifo #(
    .WIDTH(sar_readout_pkg::RESULT_W),
    .DEPTH(sar_readout_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push_q),
    .in_ready(capture_ready),
    .in_data(code_q ^ sar_readout_pkg::TRIAL_MSB),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data.code)
  );
endmodule
`default_nettype wire

// ===== test/sar_readout_monitor.sv
// Purpose: Port checker for the serial readout
// Assumes: Frame falls counted like the block
// Notes: Bound at the foot
`default_nettype none
module sar_readout_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic shift_clock,
  input wire sar_readout_pkg::serial_out_t data_out,
  input wire logic sample_en,
  input wire logic [13:0] dac_code,
  input wire logic power_down,
  input wire logic capture_ready,
  input wire logic result_valid,
  input wire logic result_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [5:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) sck_q <= 1'b0;
    else sck_q <= shift_clock;
  // Saturates so a long frame cannot wrap
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) cnt_q <= 6'h00;
    else if (cs_n) cnt_q <= 6'h00;
    else if (sck_q && !shift_clock && cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_pd_quiet: assert property (power_down |-> !sample_en && !data_out.oe)
    else $error("activity in power down");
  chk_cs_tristate: assert property (cs_n && $past(cs_n) && $past(cs_n, 2)
    |-> !data_out.oe && power_down) else $error("output not released");
  chk_sample_quiet: assert property (sample_en |-> !data_out.oe)
    else $error("output driven while sampling");
  chk_enable_fifth: assert property ($rose(data_out.oe)
    |-> cnt_q == 6'h05 && !data_out.data) else $error("output enable not at fifth fall");
  chk_hold_fifth: assert property ($fell(sample_en) && !$past(cs_n)
    |-> cnt_q == 6'h05) else $error("hold not at fifth fall");
  chk_trial_start: assert property ($rose(data_out.oe)
    |-> dac_code == 14'h2000) else $error("conversion not started");
  chk_dummy_zero: assert property ((cnt_q == 6'h14 || cnt_q == 6'h15) &&
    $past(cnt_q) == cnt_q |-> !data_out.data) else $error("dummy bit high");
  chk_bit_timing: assert property ($changed(data_out.data) |->
    ($past(sck_q) && !$past(shift_clock)) || $past(cs_n)) else $error("bit moved");
  cover property ($rose(data_out.oe));
  cover property (!capture_ready);
  cover property (result_valid && result_ready);
endmodule
bind sar_adc_serial_readout sar_readout_monitor mon (.clk(clk), .reset_n(reset_n),
  .cs_n(cs_n), .shift_clock(shift_clock), .data_out(data_out), .sample_en(sample_en),
  .dac_code(dac_code), .power_down(power_down), .capture_ready(capture_ready),
  .result_valid(result_valid), .result_ready(result_ready));
`default_nettype wire

// ===== test/analog_array_model.sv
// Purpose: Sampled input and comparator of the array
// Assumes: Target is a two's complement code
// Notes: Later target changes are unseen once held
`default_nettype none
module analog_array_model (
  input wire logic clk,
  input wire logic sample_en,
  input wire logic [13:0] dac_code,
  input wire logic [13:0] target,
  output logic comp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] held_q;
  always_ff @(posedge clk)
    if (sample_en) held_q <= target;
  assign comp_above = (held_q ^ 14'h2000) >= dac_code;
endmodule
`default_nettype wire

// ===== test/sar_adc_serial_readout_test.sv
// Purpose: Self-checking bench for the serial readout
// Assumes: Host uses the shortest legal high phase and the shortest legal period
// Notes: Bits are read just before each rising shift clock
`default_nettype none
module sar_adc_serial_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  // high phase at the 200ns minimum
  localparam int PH = sar_readout_pkg::SCK_MIN_PHASE_CYC;
  // period no shorter than that of 1.2MHz (1200 kHz), in clk cycles
  localparam int SCK_PERIOD_CYC = (1_000_000_000 / 1200 + sar_readout_pkg::CLK_PERIOD_PS - 1)
    / sar_readout_pkg::CLK_PERIOD_PS;
  localparam int PH_LO = SCK_PERIOD_CYC - PH;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n = 1'b1;
  logic shift_clock = 1'b0;
  logic result_ready = 1'b0;
  logic [13:0] target = 14'h0000;
  logic comp_above, sample_en, power_down, capture_ready, result_valid;
  logic [13:0] dac_code;
  sar_readout_pkg::serial_out_t data_out;
  sar_readout_pkg::result_word_t result_data;
  logic bits [1:36];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  sar_adc_serial_readout dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .shift_clock(shift_clock), .data_out(data_out), .sample_en(sample_en),
    .dac_code(dac_code), .comp_above(comp_above), .power_down(power_down),
    .capture_ready(capture_ready), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data));
  analog_array_model array (.clk(clk), .sample_en(sample_en), .dac_code(dac_code),
    .target(target), .comp_above(comp_above));
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_frame(input logic [13:0] v, input int n);
    target <= v;
    // chip select low starts the frame
    cs_n <= 1'b0;
    repeat (PH) @(posedge clk);
    for (int i = 1; i <= n; i++)
    begin
      shift_clock <= 1'b1;
      // Changing the input after hold must not move the result
      if (i == 6) target <= ~v;
      repeat (PH) @(posedge clk);
      shift_clock <= 1'b0;
      repeat (PH_LO - 1) @(posedge clk);
      @(negedge clk);
      bits[i] = data_out.data;
      if (i == 4) cmp_bit(sample_en & ~data_out.oe, 1'b1);
      if (i == 5) cmp_bit(data_out.oe & ~sample_en, 1'b1);
      @(posedge clk);
    end
    // chip select high after the n-th shift clock fall
    cs_n <= 1'b1;
    repeat (4) @(negedge clk);
    cmp_bit(~data_out.oe & power_down, 1'b1);
    @(posedge clk);
  endtask
  task automatic pop(input logic [13:0] exp);
    @(negedge clk);
    cmp_bit(result_valid, 1'b1);
    cmp_word(result_data.code, exp);
    @(posedge clk);
    result_ready <= 1'b1;
    @(posedge clk);
    result_ready <= 1'b0;
  endtask
  task automatic test_readout();
    logic [13:0] tbl [5] = '{14'h0000, 14'h1fff, 14'h2000, 14'h3fff, 14'h1555};
    foreach (tbl[j])
    begin
      run_frame(tbl[j], 36);
      cmp_bit(bits[5] | bits[20] | bits[21], 1'b0);
      for (int k = 0; k < 14; k++)
      begin
        cmp_bit(bits[6 + k], tbl[j][13 - k]);
        cmp_bit(bits[22 + k], tbl[j][k]);
      end
      pop(tbl[j]);
    end
  endtask
  task automatic test_abort();
    run_frame(14'h0abc, 10);
    // Clocks while deselected must start nothing
    repeat (4)
    begin
      shift_clock <= ~shift_clock;
      repeat (PH_LO) @(posedge clk);
    end
    @(negedge clk);
    cmp_bit(power_down & ~sample_en, 1'b1);
    cmp_bit(result_valid, 1'b0);
    @(posedge clk);
  endtask
  task automatic test_fifo_full();
    for (int i = 0; i < 9; i++) run_frame(14'(i * 1843), 24);
    @(negedge clk);
    cmp_bit(capture_ready, 1'b0);
    @(posedge clk);
    for (int i = 0; i < 8; i++) pop(14'(i * 1843));
    @(negedge clk);
    cmp_bit(result_valid, 1'b0);
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    // All scenarios take about 69k cycles at the legal clock pace
    if (cycles == 80000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_readout();
    test_abort();
    test_fifo_full();
    final_report();
  end
endmodule
`default_nettype wire
